// ---- design/rfc_core.sv ----
// Purpose: key sector interpreter for recovery limits and feature control
// Assumes: key words written over APB, then a go bit starts decoding
// Notes:   zero-wait APB slave; recovery timer watches host command events
//
// Functional notes
// - action 0003h selects set or report of read/write recovery limits.
// - recovery word 2: 0001h read timer, 0002h write timer.
// - set function puts word 3 as new limit in 100 ms units.
// - abort a set below 65 units (6.5 seconds).
// - report returns limit low byte in count, high in number, 00h/50h.
// - non-queued commands are timed to completion at host interface.
// - queued in-order commands start timing when execution begins.
// - no timing for streaming or out-of-order queued commands.
// - recovery limits are volatile, default zero meaning no time-out.
// - action 0004h selects feature control.
// - feature function 0001h sets the addressed feature state.
// - feature function 0002h reports the current feature state.
// - feature function 0003h reports the feature option flags.
// - feature code in word 2, state value in word 3.
// - set with option bit 0 high keeps state across power cycles; here kept across hard reset only, rst reloads FEAT_DEF.
// - option bit 0 low is volatile; hard reset restores saved state.
// - feature report in count (low) and number (high), status 50h.
// - write cache states 1 set-features, 2 force on, 3 force off.
`timescale 1ns/1ps
module rfc_core #(
    parameter int TICK_CYCLES = rfc_pkg::TICK_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        hard_reset_pin,
    input  wire logic        cmd_arrive,
    input  wire logic        cmd_exec,
    input  wire logic        cmd_done,
    input  wire logic        cmd_write,
    input  wire logic        cmd_queued,
    input  wire logic        cmd_stream,
    input  wire logic        ooo_enable,
    output logic             cmd_timeout,
    output logic             tf_valid,
    output logic [7:0]       tf_error,
    output logic [7:0]       tf_count,
    output logic [7:0]       tf_number,
    output logic [7:0]       tf_status,
    output logic             wc_force_on,
    output logic             wc_force_off,
    output logic             reorder_on,
    output logic [15:0]      temp_interval
);
    typedef struct packed {
        logic [4:0][15:0]    key;
        logic                go;
        logic [15:0]         rlim;
        logic [15:0]         wlim;
        logic [2:0][15:0]    fstate;
        logic [2:0][15:0]    fsaved;
        logic [2:0][15:0]    fopt;
        logic                valid;
        logic [7:0]          err;
        logic [7:0]          cnt;
        logic [7:0]          num;
        logic [7:0]          stat;
        rfc_pkg::rfc_tstate_e tst;
        logic [15:0]         tlim;
        logic [15:0]         tcnt;
        logic [31:0]         div;
        logic                texp;
        logic [2:0]          hr;
    } rfc_state_s;

    rfc_state_s s;
    rfc_state_s next_s;

    logic        wr_en;
    logic        hr_rise;
    logic        tick;
    logic [1:0]  fidx;
    logic        fsel_ok;
    logic        st_ok;
    logic [15:0] lim_sel;
    logic        start_t;

    // bus strobes and derived conditions
    assign wr_en   = psel && penable && pwrite;
    assign hr_rise = s.hr[1] && !s.hr[2];
    assign tick    = (s.div == 32'(TICK_CYCLES - 1));
    assign fidx    = 2'(s.key[2] - rfc_pkg::FC_WC);
    assign fsel_ok = (s.key[2] >= rfc_pkg::FC_WC) && (s.key[2] <= rfc_pkg::FC_TEMP);
    assign lim_sel = cmd_write ? s.wlim : s.rlim;

    // legal state value for the addressed feature
    always_comb begin
        st_ok = 1'b0;
        case (s.key[2])
            rfc_pkg::FC_WC:    st_ok = (s.key[3] >= rfc_pkg::WC_SETF) &&
                                       (s.key[3] <= rfc_pkg::WC_OFF);
            rfc_pkg::FC_REORD: st_ok = (s.key[3] == rfc_pkg::RO_ON) ||
                                       (s.key[3] == rfc_pkg::RO_OFF);
            rfc_pkg::FC_TEMP:  st_ok = (s.key[3] != rfc_pkg::ZERO_W);
            default:           st_ok = 1'b0;
        endcase
    end

    // timer start: arrival for non-queued, execution for in-order queued
    always_comb begin
        start_t = 1'b0;
        if (!cmd_stream && lim_sel != rfc_pkg::ZERO_W) begin
            if (!cmd_queued && cmd_arrive) begin
                start_t = 1'b1;
            end else if (cmd_queued && !ooo_enable && cmd_exec) begin
                start_t = 1'b1;
            end
        end
    end

    // next state: bus writes, decoder, timer, hard reset
    always_comb begin
        next_s       = s;
        next_s.go    = 1'b0;
        next_s.valid = 1'b0;
        next_s.hr    = {s.hr[1:0], hard_reset_pin};
        // register writes
        if (wr_en) begin
            case (paddr)
                rfc_pkg::A_KEY0: next_s.key[0] = pwdata[15:0];
                rfc_pkg::A_KEY1: next_s.key[1] = pwdata[15:0];
                rfc_pkg::A_KEY2: next_s.key[2] = pwdata[15:0];
                rfc_pkg::A_KEY3: next_s.key[3] = pwdata[15:0];
                rfc_pkg::A_KEY4: next_s.key[4] = pwdata[15:0];
                rfc_pkg::A_CTRL: next_s.go = pwdata[rfc_pkg::CTRL_GO];
                rfc_pkg::A_TSTAT: begin
                    if (pwdata[rfc_pkg::TS_EXP]) begin
                        next_s.texp = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // key sector decode, one cycle after the go write
        if (s.go) begin
            next_s.valid = 1'b1;
            next_s.err   = rfc_pkg::ERR_ABRT;
            next_s.stat  = rfc_pkg::ST_ERR;
            next_s.cnt   = 8'h00;
            next_s.num   = 8'h00;
            case (s.key[0])
                rfc_pkg::ACT_ERC: begin
                    if (s.key[2] == rfc_pkg::SEL_RD || s.key[2] == rfc_pkg::SEL_WR) begin
                        if (s.key[1] == rfc_pkg::FN_SET && s.key[3] >= rfc_pkg::MIN_LIM) begin
                            next_s.err  = rfc_pkg::ERR_OK;
                            next_s.stat = rfc_pkg::ST_OK;
                            if (s.key[2] == rfc_pkg::SEL_RD) begin
                                next_s.rlim = s.key[3];
                            end else begin
                                next_s.wlim = s.key[3];
                            end
                        end else if (s.key[1] == rfc_pkg::FN_GET) begin
                            next_s.err  = rfc_pkg::ERR_OK;
                            next_s.stat = rfc_pkg::ST_OK;
                            if (s.key[2] == rfc_pkg::SEL_RD) begin
                                next_s.cnt = s.rlim[7:0];
                                next_s.num = s.rlim[15:8];
                            end else begin
                                next_s.cnt = s.wlim[7:0];
                                next_s.num = s.wlim[15:8];
                            end
                        end
                    end
                end
                rfc_pkg::ACT_FC: begin
                    if (fsel_ok) begin
                        if (s.key[1] == rfc_pkg::FN_SET && st_ok) begin
                            next_s.err          = rfc_pkg::ERR_OK;
                            next_s.stat         = rfc_pkg::ST_OK;
                            next_s.fstate[fidx] = s.key[3];
                            next_s.fopt[fidx]   = s.key[4];
                            if (s.key[4][rfc_pkg::OPT_KEEP]) begin
                                next_s.fsaved[fidx] = s.key[3];
                            end
                        end else if (s.key[1] == rfc_pkg::FN_GET) begin
                            next_s.err  = rfc_pkg::ERR_OK;
                            next_s.stat = rfc_pkg::ST_OK;
                            next_s.cnt  = s.fstate[fidx][7:0];
                            next_s.num  = s.fstate[fidx][15:8];
                        end else if (s.key[1] == rfc_pkg::FN_OPT) begin
                            next_s.err  = rfc_pkg::ERR_OK;
                            next_s.stat = rfc_pkg::ST_OK;
                            next_s.cnt  = s.fopt[fidx][7:0];
                            next_s.num  = s.fopt[fidx][15:8];
                        end
                    end
                end
                default: ;
            endcase
        end
        // recovery timer in 100 ms ticks
        next_s.div = tick ? 32'h0 : s.div + 32'h1;
        case (s.tst)
            rfc_pkg::RFC_T_IDLE: begin
                next_s.div = 32'h0;
                if (start_t) begin
                    next_s.tst  = rfc_pkg::RFC_T_RUN;
                    next_s.tlim = lim_sel;
                    next_s.tcnt = 16'h0;
                end
            end
            rfc_pkg::RFC_T_RUN: begin
                if (cmd_done) begin
                    next_s.tst = rfc_pkg::RFC_T_IDLE;
                end else if (tick) begin
                    next_s.tcnt = s.tcnt + 16'h1;
                    if (s.tcnt + 16'h1 >= s.tlim) begin
                        next_s.tst  = rfc_pkg::RFC_T_EXP;
                        next_s.texp = 1'b1; // set wins over clear
                    end
                end
            end
            rfc_pkg::RFC_T_EXP: next_s.tst = rfc_pkg::RFC_T_IDLE;
            default:            next_s.tst = rfc_pkg::RFC_T_IDLE;
        endcase
        // hard reset drops volatile settings
        if (hr_rise) begin
            next_s.rlim   = rfc_pkg::ZERO_W;
            next_s.wlim   = rfc_pkg::ZERO_W;
            next_s.fstate = s.fsaved;
            next_s.tst    = rfc_pkg::RFC_T_IDLE;
        end
    end

    // state register with power-on defaults
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s        <= '0;
            s.fstate <= {3{rfc_pkg::FEAT_DEF}};
            s.fsaved <= {3{rfc_pkg::FEAT_DEF}};
            s.tst    <= rfc_pkg::RFC_T_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // read mux, zero wait states, error on unmapped address
    always_comb begin
        prdata  = 32'h0;
        pslverr = 1'b0;
        case (paddr)
            rfc_pkg::A_KEY0:   prdata = {16'h0, s.key[0]};
            rfc_pkg::A_KEY1:   prdata = {16'h0, s.key[1]};
            rfc_pkg::A_KEY2:   prdata = {16'h0, s.key[2]};
            rfc_pkg::A_KEY3:   prdata = {16'h0, s.key[3]};
            rfc_pkg::A_KEY4:   prdata = {16'h0, s.key[4]};
            rfc_pkg::A_CTRL:   prdata = {31'h0, s.go};
            rfc_pkg::A_RESULT: prdata = {s.stat, s.err, s.num, s.cnt};
            rfc_pkg::A_RTIME:  prdata = {s.wlim, s.rlim};
            rfc_pkg::A_TSTAT:  prdata = {30'h0, s.tst == rfc_pkg::RFC_T_RUN, s.texp};
            rfc_pkg::A_FEAT:   prdata = {s.fstate[1], s.fstate[0]};
            default:           pslverr = psel && penable;
        endcase
    end

    // outputs from the state register, pready tied high
    assign pready        = 1'b1;
    assign cmd_timeout   = (s.tst == rfc_pkg::RFC_T_EXP);
    assign tf_valid      = s.valid;
    assign tf_error      = s.err;
    assign tf_count      = s.cnt;
    assign tf_number     = s.num;
    assign tf_status     = s.stat;
    assign wc_force_on   = (s.fstate[0] == rfc_pkg::WC_ON);
    assign wc_force_off  = (s.fstate[0] == rfc_pkg::WC_OFF);
    assign reorder_on    = (s.fstate[1] == rfc_pkg::RO_ON);
    assign temp_interval = s.fstate[2];

    // checks on the decoder, hard reset and timer start
    set_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.go && s.key[0] == rfc_pkg::ACT_ERC && s.key[1] == rfc_pkg::FN_SET &&
        s.key[2] == rfc_pkg::SEL_RD && s.key[3] >= rfc_pkg::MIN_LIM && !hr_rise
        |=> s.rlim == $past(s.key[3]) && tf_status == rfc_pkg::ST_OK)
        else $error("read limit not stored");
    set_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.go && s.key[0] == rfc_pkg::ACT_ERC && s.key[1] == rfc_pkg::FN_SET &&
        s.key[2] == rfc_pkg::SEL_WR && s.key[3] >= rfc_pkg::MIN_LIM && !hr_rise
        |=> s.wlim == $past(s.key[3]) && $stable(s.rlim))
        else $error("write limit not stored");
    min_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.go && s.key[0] == rfc_pkg::ACT_ERC && s.key[1] == rfc_pkg::FN_SET &&
        s.key[3] < rfc_pkg::MIN_LIM
        |=> tf_error == rfc_pkg::ERR_ABRT && tf_status == rfc_pkg::ST_ERR)
        else $error("short limit not aborted");
    get_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.go && s.key[0] == rfc_pkg::ACT_ERC && s.key[1] == rfc_pkg::FN_GET &&
        s.key[2] == rfc_pkg::SEL_RD
        |=> {tf_number, tf_count} == $past(s.rlim) && tf_error == rfc_pkg::ERR_OK
            && tf_status == rfc_pkg::ST_OK && tf_valid)
        else $error("limit report wrong");
    hard_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        hr_rise |=> s.rlim == rfc_pkg::ZERO_W && s.wlim == rfc_pkg::ZERO_W &&
        s.fstate == $past(s.fsaved))
        else $error("volatile settings kept");
    start_now_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.tst == rfc_pkg::RFC_T_IDLE && cmd_arrive && !cmd_queued && !cmd_stream &&
        lim_sel != rfc_pkg::ZERO_W && !hr_rise
        |=> s.tst == rfc_pkg::RFC_T_RUN ##0 s.tcnt == 16'h0)
        else $error("timer did not start");
    queued_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.tst == rfc_pkg::RFC_T_IDLE && cmd_queued && cmd_arrive && !cmd_exec
        |=> s.tst == rfc_pkg::RFC_T_IDLE)
        else $error("queued timer started on arrival");
    no_stream_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.tst == rfc_pkg::RFC_T_IDLE && (cmd_stream || (cmd_queued && ooo_enable))
        |=> s.tst == rfc_pkg::RFC_T_IDLE)
        else $error("timer ran for excluded command");
    keep_state_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.go && s.key[0] == rfc_pkg::ACT_FC && s.key[1] == rfc_pkg::FN_SET &&
        fsel_ok && st_ok && s.key[4][rfc_pkg::OPT_KEEP]
        |=> s.fsaved[$past(fidx)] == $past(s.key[3]) && tf_status == rfc_pkg::ST_OK)
        else $error("saved state not updated");
    bad_code_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.go && (s.key[1] == rfc_pkg::ZERO_W || s.key[1] > rfc_pkg::FN_OPT)
        |=> tf_error == rfc_pkg::ERR_ABRT ##1 !tf_valid)
        else $error("bad function not aborted");

    // expiry raises the one-cycle pulse and the sticky flag together
    expire_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.tst == rfc_pkg::RFC_T_RUN && tick && !cmd_done && !hr_rise &&
        s.tcnt + 16'h1 >= s.tlim
        |=> cmd_timeout && s.texp)
        else $error("timer expiry missed");

    // feature report returns the stored state split over two bytes
    get_state_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.go && s.key[0] == rfc_pkg::ACT_FC && s.key[1] == rfc_pkg::FN_GET && fsel_ok
        |=> {tf_number, tf_count} == $past(s.fstate[fidx]) && tf_status == rfc_pkg::ST_OK)
        else $error("feature report wrong");
endmodule

// ---- design/rfc_pkg.sv ----
// Purpose: constants shared by the recovery and feature control interpreter
// Assumes: 200 MHz reference clock, 32-bit register bus
// Notes:   key sector words are 16 bits; results mirror the task-file bytes
package rfc_pkg;
    // key sector codes
    localparam logic [15:0] ACT_ERC   = 16'h0003;  // recovery time limits
    localparam logic [15:0] ACT_FC    = 16'h0004;  // feature control
    localparam logic [15:0] FN_SET    = 16'h0001;
    localparam logic [15:0] FN_GET    = 16'h0002;
    localparam logic [15:0] FN_OPT    = 16'h0003;
    localparam logic [15:0] SEL_RD    = 16'h0001;
    localparam logic [15:0] SEL_WR    = 16'h0002;
    localparam logic [15:0] MIN_LIM   = 16'h0041;  // 65 units = 6.5 s
    localparam logic [15:0] ZERO_W    = 16'h0000;
    // feature codes and states
    localparam logic [15:0] FC_WC     = 16'h0001;
    localparam logic [15:0] FC_REORD  = 16'h0002;
    localparam logic [15:0] FC_TEMP   = 16'h0003;
    localparam logic [15:0] WC_SETF   = 16'h0001;
    localparam logic [15:0] WC_ON     = 16'h0002;
    localparam logic [15:0] WC_OFF    = 16'h0003;
    localparam logic [15:0] RO_ON     = 16'h0001;
    localparam logic [15:0] RO_OFF    = 16'h0002;
    localparam logic [15:0] FEAT_DEF  = 16'h0001;
    localparam int          NUM_FEAT  = 3;
    localparam int          OPT_KEEP  = 0;         // option flag: non-volatile
    // task-file answers
    localparam logic [7:0]  ERR_OK    = 8'h00;
    localparam logic [7:0]  ERR_ABRT  = 8'h04;
    localparam logic [7:0]  ST_OK     = 8'h50;
    localparam logic [7:0]  ST_ERR    = 8'h51;
    // register byte addresses
    localparam int          ADDR_W    = 8;
    localparam logic [7:0]  A_KEY0    = 8'h00;
    localparam logic [7:0]  A_KEY1    = 8'h04;
    localparam logic [7:0]  A_KEY2    = 8'h08;
    localparam logic [7:0]  A_KEY3    = 8'h0C;
    localparam logic [7:0]  A_KEY4    = 8'h10;
    localparam logic [7:0]  A_CTRL    = 8'h14;
    localparam logic [7:0]  A_RESULT  = 8'h18;
    localparam logic [7:0]  A_RTIME   = 8'h1C;
    localparam logic [7:0]  A_TSTAT   = 8'h20;
    localparam logic [7:0]  A_FEAT    = 8'h24;
    localparam int          CTRL_GO   = 0;
    localparam int          TS_EXP    = 0;
    localparam int          TS_RUN    = 1;
    // timing: one limit unit in ms, clock in kHz
    localparam int          UNIT_MS   = 100;
    localparam int          CLK_KHZ   = 200000;
    localparam int          TICK_CYC  = UNIT_MS * CLK_KHZ;
    typedef enum logic [1:0] {
        RFC_T_IDLE = 2'b00,
        RFC_T_RUN  = 2'b01,
        RFC_T_EXP  = 2'b11
    } rfc_tstate_e;
endpackage

// ---- verification/rfc_host_model.sv ----
// Purpose: host side command source feeding drive command events
// Assumes: same clock as the interpreter, one command in flight at a time
// Notes:   a queued command starts executing a programmable gap after arrival
`timescale 1ns/1ps
module rfc_host_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic       finish,
    input  wire logic       queued,
    input  wire logic       stream,
    input  wire logic       ooo,
    input  wire logic       wr,
    input  wire logic [7:0] gap,
    output logic            cmd_arrive,
    output logic            cmd_exec,
    output logic            cmd_done,
    output logic            cmd_write,
    output logic            cmd_queued,
    output logic            cmd_stream,
    output logic            ooo_enable
);
    logic [8:0] wait_cnt;  // zero while no execution start is pending
    // arrival pulse, levels held with it, delayed execution start, completion
    always_ff @(posedge ref_clk) begin
        cmd_arrive <= 1'b0;
        cmd_exec   <= 1'b0;
        cmd_done   <= finish;  // completion at the host interface
        if (rst) begin
            cmd_write  <= 1'b0;
            cmd_queued <= 1'b0;
            cmd_stream <= 1'b0;
            ooo_enable <= 1'b0;
            wait_cnt   <= 9'h000;
        end else if (start) begin
            cmd_arrive <= 1'b1;
            cmd_write  <= wr;
            cmd_queued <= queued;
            cmd_stream <= stream;  // streaming traffic only; reordering is carried on ooo_enable
            ooo_enable <= ooo;
            wait_cnt   <= queued ? {1'b0, gap} + 9'h001 : 9'h000;  // late start
        end else if (wait_cnt == 9'h001) begin
            cmd_exec <= 1'b1;
            wait_cnt <= 9'h000;
        end else if (wait_cnt != 9'h000) begin
            wait_cnt <= wait_cnt - 9'h001;
        end
    end
endmodule

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for the recovery and feature interpreter
// Assumes: zero-wait APB slave, short limit tick set by parameter
// Notes:   random limits and intervals from a fixed seed
`timescale 1ns/1ps
module tb_top;
    localparam int TK = 4;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, h_gap = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, r;
    logic pready, pslverr, slv, hrst = 1'b0, h_start = 1'b0, h_fin = 1'b0;
    logic h_q = 1'b0, h_s = 1'b0, h_o = 1'b0, h_w = 1'b0;
    logic cmd_arrive, cmd_exec, cmd_done, cmd_write, cmd_queued, cmd_stream, ooo_enable;
    logic cmd_timeout, tf_valid, wc_force_on, wc_force_off, reorder_on;
    logic [7:0] tf_error, tf_count, tf_number, tf_status;
    logic [15:0] temp_interval, wl, tv;
    int n_fail = 0, checks = 0;
    // clock at 200 MHz
    always #2.5 ref_clk = ~ref_clk;
    rfc_core #(.TICK_CYCLES(TK)) dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .hard_reset_pin(hrst),
        .cmd_arrive(cmd_arrive), .cmd_exec(cmd_exec), .cmd_done(cmd_done),
        .cmd_write(cmd_write), .cmd_queued(cmd_queued), .cmd_stream(cmd_stream),
        .ooo_enable(ooo_enable), .cmd_timeout(cmd_timeout), .tf_valid(tf_valid),
        .tf_error(tf_error), .tf_count(tf_count), .tf_number(tf_number),
        .tf_status(tf_status), .wc_force_on(wc_force_on), .wc_force_off(wc_force_off),
        .reorder_on(reorder_on), .temp_interval(temp_interval));
    rfc_host_model host (.ref_clk(ref_clk), .rst(rst), .start(h_start), .finish(h_fin),
        .queued(h_q), .stream(h_s), .ooo(h_o), .wr(h_w), .gap(h_gap),
        .cmd_arrive(cmd_arrive), .cmd_exec(cmd_exec), .cmd_done(cmd_done),
        .cmd_write(cmd_write), .cmd_queued(cmd_queued), .cmd_stream(cmd_stream),
        .ooo_enable(ooo_enable));
    // expected task-file words
    function automatic logic [31:0] ok(input logic [15:0] v);
        return {rfc_pkg::ST_OK, rfc_pkg::ERR_OK, v};
    endfunction
    function automatic logic [31:0] bad();
        return {rfc_pkg::ST_ERR, rfc_pkg::ERR_ABRT, 16'h0000};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // key sector words, then go; result read the cycle after
    task automatic sct(input logic [15:0] w0, w1, w2, w3, w4);
        apb(1'b1, rfc_pkg::A_KEY0, {16'h0000, w0});
        apb(1'b1, rfc_pkg::A_KEY1, {16'h0000, w1});
        apb(1'b1, rfc_pkg::A_KEY2, {16'h0000, w2});
        apb(1'b1, rfc_pkg::A_KEY3, {16'h0000, w3});
        apb(1'b1, rfc_pkg::A_KEY4, {16'h0000, w4});
        apb(1'b1, rfc_pkg::A_CTRL, 32'h0000_0001);
        @(posedge ref_clk);
        #1;
        chk("tf_valid", 32'h1, {31'h0, tf_valid});
        r = {tf_status, tf_error, tf_number, tf_count};
    endtask
    // one host command; lim zero means no time-out is expected
    task automatic run_cmd(input logic qd, sd, od, wd, input int lim);
        int n;
        @(posedge ref_clk);
        {h_q, h_s, h_o, h_w} <= {qd, sd, od, wd};
        h_gap <= 8'(10 + $urandom % 50);
        h_start <= 1'b1;
        @(posedge ref_clk);
        h_start <= 1'b0;
        n = 0;
        #1;
        while ((qd ? cmd_exec : cmd_arrive) !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        n = 0;
        while (cmd_timeout !== 1'b1 && n < 65 * TK + lim * TK + 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (lim == 0) chk("no timeout", 32'h0, {31'h0, cmd_timeout});
        else chk("timeout cycles", lim * TK, (n >= lim * TK - 3 && n <= lim * TK + 3) ? lim * TK : n);
        @(posedge ref_clk);
        h_fin <= 1'b1;
        @(posedge ref_clk);
        h_fin <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    // watchdog sized well above the longest run
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_fail++;
        end_sim();
    end
    // main sequence
    initial begin
        void'($urandom(7662));
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, rfc_pkg::A_RTIME, 32'h0);
        chk("limits at reset", 32'h0, q);
        apb(1'b0, rfc_pkg::A_FEAT, 32'h0);
        chk("features at reset", {rfc_pkg::FEAT_DEF, rfc_pkg::FEAT_DEF}, q);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, slv});
        sct(rfc_pkg::ACT_ERC, rfc_pkg::FN_SET, rfc_pkg::SEL_RD, 16'h0040, 16'h0);
        chk("limit 64", bad(), r);
        sct(rfc_pkg::ACT_ERC, rfc_pkg::FN_SET, rfc_pkg::SEL_RD, rfc_pkg::MIN_LIM, 16'h0);
        chk("limit 65", ok(16'h0) >> 16, r >> 16);
        wl = 16'(66 + $urandom % 200);
        sct(rfc_pkg::ACT_ERC, rfc_pkg::FN_SET, rfc_pkg::SEL_WR, wl, 16'h0);
        sct(rfc_pkg::ACT_ERC, rfc_pkg::FN_GET, rfc_pkg::SEL_RD, 16'h0, 16'h0);
        chk("read limit", ok(rfc_pkg::MIN_LIM), r);
        apb(1'b0, rfc_pkg::A_RESULT, 32'h0);
        chk("result register", ok(rfc_pkg::MIN_LIM), q);
        sct(rfc_pkg::ACT_ERC, rfc_pkg::FN_GET, rfc_pkg::SEL_WR, 16'h0, 16'h0);
        chk("write limit", ok(wl), r);
        apb(1'b0, rfc_pkg::A_RTIME, 32'h0);
        chk("limit register", {wl, rfc_pkg::MIN_LIM}, q);
        sct(rfc_pkg::ACT_ERC, rfc_pkg::FN_GET, 16'h0003, 16'h0, 16'h0);
        chk("bad selection", bad(), r);
        sct(16'h0006, rfc_pkg::FN_GET, rfc_pkg::SEL_RD, 16'h0, 16'h0);
        chk("bad action", bad(), r);
        sct(rfc_pkg::ACT_FC, 16'h0005, rfc_pkg::FC_WC, 16'h0001, 16'h0);
        chk("bad function", bad(), r);
        for (int s = 1; s <= 3; s++) begin
            sct(rfc_pkg::ACT_FC, rfc_pkg::FN_SET, rfc_pkg::FC_WC, 16'(s), 16'h0);
            chk("cache forced", {s == 2, s == 3}, {wc_force_on, wc_force_off});
            sct(rfc_pkg::ACT_FC, rfc_pkg::FN_GET, rfc_pkg::FC_WC, 16'h0, 16'h0);
            chk("cache state", ok(16'(s)), r);
        end
        sct(rfc_pkg::ACT_FC, rfc_pkg::FN_SET, rfc_pkg::FC_WC, rfc_pkg::WC_ON, 16'h1);
        sct(rfc_pkg::ACT_FC, rfc_pkg::FN_SET, rfc_pkg::FC_REORD, rfc_pkg::RO_OFF, 16'h0);
        chk("reorder off", 32'h0, {31'h0, reorder_on});
        sct(rfc_pkg::ACT_FC, rfc_pkg::FN_OPT, rfc_pkg::FC_WC, 16'h0, 16'h0);
        chk("option flags", ok(16'h0001), r);
        tv = 16'(2 + $urandom % 16'hFFFD);
        sct(rfc_pkg::ACT_FC, rfc_pkg::FN_SET, rfc_pkg::FC_TEMP, tv, 16'h0);
        chk("interval", {16'h0, tv}, {16'h0, temp_interval});
        sct(rfc_pkg::ACT_FC, rfc_pkg::FN_SET, rfc_pkg::FC_TEMP, 16'h0000, 16'h0);
        chk("zero interval", bad(), r);
        run_cmd(1'b0, 1'b0, 1'b0, 1'b0, 65);
        apb(1'b0, rfc_pkg::A_TSTAT, 32'h0);
        chk("sticky timeout", 32'h1, q);
        apb(1'b1, rfc_pkg::A_TSTAT, 32'h1);
        apb(1'b0, rfc_pkg::A_TSTAT, 32'h0);
        chk("timeout cleared", 32'h0, q);
        run_cmd(1'b1, 1'b0, 1'b0, 1'b1, int'(wl));
        run_cmd(1'b0, 1'b1, 1'b0, 1'b0, 0);
        run_cmd(1'b1, 1'b0, 1'b1, 1'b0, 0);
        @(posedge ref_clk);
        hrst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        hrst <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        chk("kept cache", 32'h1, {31'h0, wc_force_on});
        chk("volatile revert", {1'b1, rfc_pkg::FEAT_DEF}, {reorder_on, temp_interval});
        apb(1'b0, rfc_pkg::A_RTIME, 32'h0);
        chk("limits after hard reset", 32'h0, q);
        end_sim();
    end
endmodule
